// File: bslu_core.sv
`timescale 1ns/100ps
`default_nettype none
module bslu_core
  import bslu_pkg::*;
(
  // Operation
  input wire bslu_req_s req,
  // Combinational answer
  output logic [31:0] result,
  output logic writes,
  output logic flow,
  output logic probe,
  output logic found,
  output logic [4:0] position
);

  // ==========================================================
  // Width handling
  wire [31:0] wmask = req.dword ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  wire [31:0] a = req.first_source_ref & wmask;
  wire [31:0] b = req.second_source_ref & wmask;
  wire [4:0] n = req.dword ? req.count : {1'b0, req.count[3:0]};
  wire [31:0] onehot = 32'h0000_0001 << n;
  wire [31:0] fill = {32{req.fill_bit}};

  function automatic logic [31:0] rot_l(input logic [31:0] v,
    input logic [4:0] k, input logic dw);
    logic [63:0] d;
    logic [31:0] w;
    d = {v, v} << k;
    w = {v[15:0], v[15:0]} << k;
    rot_l = dw ? d[63:32] : {16'h0000, w[31:16]};
  endfunction

  wire [4:0] nr = req.dword ? 5'(6'h20 - {1'b0, n}) : 5'(5'h10 - n);
  wire [31:0] shift_msb_v =
    ((a << n) | (fill & ~(32'hFFFF_FFFF << n))) & wmask;
  wire [31:0] shift_lsb_v = (a >> n) & wmask;
  wire [31:0] rot_msb_v = rot_l(a, n, req.dword);
  wire [31:0] rot_lsb_v = (n == 5'h00) ? a : rot_l(a, nr, req.dword);
  wire [31:0] lowest = a & (~a + 32'h0000_0001);

  function automatic logic [4:0] enc(input logic [31:0] v);
    logic [4:0] p;
    p = 5'h00;
    for (int i = 0; i < 32; i++)
      if (v[i])
        p = 5'(i);
    enc = p;
  endfunction

  wire is_tst = req.func_code == BSLU_FN_TST;
  wire is_pos = req.func_code == BSLU_FN_POS;
  wire is_shift = req.func_code == BSLU_FN_SHIFT_TOWARD_MSB;

  always_comb
  begin
    result = 32'h0000_0000;
    writes = !(is_tst || is_pos);
    unique case (req.func_code)
      BSLU_FN_AND: result = a & b; // RL3
      BSLU_FN_OR: result = a | b; // RL4
      BSLU_FN_XOR: result = a ^ b; // RL9
      BSLU_FN_NOT: result = ~a & wmask; // RL10
      BSLU_FN_SHIFT_TOWARD_MSB: result = shift_msb_v; // RL11
      BSLU_FN_SHIFT_TOWARD_LSB: result = shift_lsb_v; // RL11
      BSLU_FN_ROTATE_TOWARD_MSB: result = rot_msb_v; // RL12
      BSLU_FN_ROTATE_TOWARD_LSB: result = rot_lsb_v; // RL12
      BSLU_FN_SET: result = a | onehot; // RL13
      BSLU_FN_CLR: result = a & ~onehot; // RL14
      default: writes = 1'b0;
    endcase
  end

  // Shift-left flow is the last bit pushed out of the top end
  wire [63:0] wide = {32'h0000_0000, a} << n;
  wire shift_out_bit = req.dword ? wide[32] : wide[16];
  assign flow = is_shift ? (n != 5'h00 && shift_out_bit) : 1'b1;
  assign probe = is_tst && |(a & onehot); // RL15
  assign found = is_pos && (a != 32'h0000_0000); // RL16
  assign position = enc(lowest); // RL16

endmodule
`default_nettype wire

// File: bslu_pkg.sv
`default_nettype none
package bslu_pkg;

  // ==========================================================
  // Operand widths
  localparam int unsigned BSLU_WORD_W = 16;
  localparam int unsigned BSLU_DWORD_W = 32;
  localparam int unsigned BSLU_POS_W = 5;

  // ==========================================================
  // Function codes
  localparam logic [7:0] BSLU_FN_AND = 8'h17;
  localparam logic [7:0] BSLU_FN_OR = 8'h19;
  localparam logic [7:0] BSLU_FN_XOR = 8'h1B;
  localparam logic [7:0] BSLU_FN_NOT = 8'h1D;
  localparam logic [7:0] BSLU_FN_SHIFT_TOWARD_MSB = 8'h1E;
  localparam logic [7:0] BSLU_FN_SHIFT_TOWARD_LSB = 8'h1F;
  localparam logic [7:0] BSLU_FN_ROTATE_TOWARD_MSB = 8'h20;
  localparam logic [7:0] BSLU_FN_ROTATE_TOWARD_LSB = 8'h21;
  localparam logic [7:0] BSLU_FN_SET = 8'h22;
  localparam logic [7:0] BSLU_FN_CLR = 8'h23;
  localparam logic [7:0] BSLU_FN_TST = 8'h24;
  localparam logic [7:0] BSLU_FN_POS = 8'h25;

  // ==========================================================
  // Reset values
  localparam logic [31:0] BSLU_RESULT_RST = 32'h0000_0000;
  localparam logic [4:0] BSLU_POS_RST = 5'h00;

  // ==========================================================
  // Request and answer carriers
  typedef struct packed {
    logic [7:0] func_code;
    logic dword;
    logic [31:0] first_source_ref;
    logic [31:0] second_source_ref;
    logic [4:0] count;
    logic fill_bit;
  } bslu_req_s;

  typedef struct packed {
    logic [31:0] result_dest_ref;
    logic result_write;
    logic power_flow;
    logic probe_bit;
    logic found;
    logic [4:0] position;
  } bslu_rsp_s;

endpackage
`default_nettype wire

// File: bslu_seq_model.sv
`timescale 1ns/100ps
`default_nettype none
module bslu_seq_model
  import bslu_pkg::*;
(
  // Scan sequencer side
  input wire logic clk,
  output logic scan_strobe,
  output logic enable_in,
  output bslu_req_s req
);
  initial
  begin
    scan_strobe = 1'b0;
    enable_in = 1'b0;
    req = '0;
  end
  // Byte aligned, non-overlapping operands of one type each
  task automatic fire(input logic en, input bslu_req_s r);
    @(negedge clk);
    scan_strobe = 1'b1;
    enable_in = en;
    req = r;
    @(negedge clk);
    scan_strobe = 1'b0;
    enable_in = !en;
    req = ~r;
  endtask
endmodule
`default_nettype wire

// File: bslu_unit.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// (RL1) Operands are words or double words, one type per operation.
// (RL2) Bit string starts at bit 1 of the first word as LSB.
// (RL3) Code 23 writes AND of the two sources bit by bit.
// (RL4) Code 25 writes OR of the two sources bit by bit.
// (RL5) AND and OR use single 16-bit words only.
// (RL6) Execute once per scan with enable power flow, never otherwise.
// (RL7) AND/OR power-flow output mirrors enable in the same scan.
// (RL8) Discrete operand addresses must be byte aligned by the programmer.
// (RL9) XOR writes 1 where the two source bits differ.
// (RL10) Invert writes the complement of every source bit.
// (RL11) Shifts move every bit by a programmed count.
// (RL12) Rotates move bits circularly, losing none.
// (RL13) Bit set forces the addressed bit to 1.
// (RL14) Bit clear forces the addressed bit to 0.
// (RL15) Bit test reports the addressed bit value.
// (RL16) Bit position reports where a 1 is found.
// (RL17) Programmer avoids overlapping source and destination ranges.
// (RL18) Without power flow the result keeps its last value.
module bslu_unit
  import bslu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Scan sequencer
  input wire logic scan_strobe,
  input wire logic enable_in,
  input wire bslu_req_s req,
  // Answer
  output bslu_rsp_s rsp,
  output logic done
);

  // ==========================================================
  // Operand conditioning
  bslu_req_s req_c;
  wire narrow = (req.func_code == BSLU_FN_AND) ||
    (req.func_code == BSLU_FN_OR);

  always_comb
  begin
    req_c = req;
    req_c.dword = req.dword && !narrow; // RL5
    if (!req_c.dword) // RL1
    begin
      req_c.first_source_ref = {16'h0000, req.first_source_ref[15:0]};
      req_c.second_source_ref = {16'h0000, req.second_source_ref[15:0]};
    end
  end

  // ==========================================================
  // Datapath
  logic [31:0] res_w;
  logic wr_w;
  logic flow_w;
  logic probe_w;
  logic found_w;
  logic [4:0] pos_w;

  bslu_core bslu_core_inst (
    .req(req_c),
    .result(res_w),
    .writes(wr_w),
    .flow(flow_w),
    .probe(probe_w),
    .found(found_w),
    .position(pos_w)
  );

  // ==========================================================
  // Scan update; one strobe is one scan
  wire run = scan_strobe && enable_in; // RL6
  bslu_rsp_s rsp_r;
  bslu_rsp_s rsp_nxt;

  always_comb
  begin
    rsp_nxt = rsp_r; // RL18
    rsp_nxt.result_write = 1'b0;
    if (scan_strobe)
    begin
      rsp_nxt.power_flow = run && flow_w; // RL7
      rsp_nxt.probe_bit = run && probe_w; // RL15
      rsp_nxt.found = run && found_w; // RL16
    end
    if (run)
    begin
      rsp_nxt.result_write = wr_w;
      if (wr_w)
        rsp_nxt.result_dest_ref = res_w; // RL2
      if (found_w)
        rsp_nxt.position = pos_w; // RL16
    end
    // Otherwise the destination is held so the last answer survives
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_r.result_dest_ref <= BSLU_RESULT_RST;
      rsp_r.result_write <= 1'b0;
      rsp_r.power_flow <= 1'b0;
      rsp_r.probe_bit <= 1'b0;
      rsp_r.found <= 1'b0;
      rsp_r.position <= BSLU_POS_RST;
      done <= 1'b0;
    end
    else
    begin
      rsp_r <= rsp_nxt;
      done <= scan_strobe;
    end
  end

  assign rsp = rsp_r;

endmodule
`default_nettype wire

// File: bslu_unit_properties.sv
`timescale 1ns/100ps
`default_nettype none
module bslu_unit_checker
  import bslu_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire logic scan_strobe,
  input wire logic enable_in,
  input wire bslu_req_s req,
  input wire bslu_rsp_s rsp,
  input wire logic done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic go = scan_strobe && enable_in;
  wire logic [7:0] fn = req.func_code;
  wire logic [15:0] sa = req.first_source_ref[15:0];
  wire logic [15:0] sb = req.second_source_ref[15:0];
  wire logic [15:0] q = rsp.result_dest_ref[15:0];
  // ==========================================================
  // Scan handshake
  property p_done; scan_strobe |=> done; endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_idle; !scan_strobe |=> !done && !rsp.result_write; endproperty
  a_idle: assert property (p_idle) else $error("idle scan act");
  property p_off; scan_strobe && !enable_in |=> !rsp.power_flow; endproperty
  a_off: assert property (p_off) else $error("flow while off");
  property p_flow;
    go && (fn == BSLU_FN_AND || fn == BSLU_FN_OR) |=> rsp.power_flow;
  endproperty
  a_flow: assert property (p_flow) else $error("flow not mirrored");
  property p_hold; !rsp.result_write |-> $stable(rsp.result_dest_ref);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  // ==========================================================
  // Word results
  property p_and; go && fn == BSLU_FN_AND |=> q == ($past(sa) & $past(sb));
  endproperty
  a_and: assert property (p_and) else $error("and wrong");
  property p_or; go && fn == BSLU_FN_OR |=> q == ($past(sa) | $past(sb));
  endproperty
  a_or: assert property (p_or) else $error("or wrong");
  property p_xor; go && fn == BSLU_FN_XOR |=> q == ($past(sa) ^ $past(sb));
  endproperty
  a_xor: assert property (p_xor) else $error("xor wrong");
  c_and: cover property (go && fn == BSLU_FN_AND);
  c_or: cover property (go && fn == BSLU_FN_OR);
  c_off: cover property (scan_strobe && !enable_in);
endmodule
bind bslu_unit bslu_unit_checker bslu_unit_checker_inst (.clk, .resetn,
  .scan_strobe, .enable_in, .req, .rsp, .done);
`default_nettype wire

// File: tb_bslu_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tb_bslu_unit;
  import bslu_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scan_strobe, enable_in, done;
  bslu_req_s req;
  bslu_rsp_s rsp;
  int n_mismatch = 0;
  int compares = 0;
  bslu_seq_model bslu_seq_model_inst (.clk, .scan_strobe, .enable_in, .req);
  bslu_unit bslu_unit_inst (.clk, .resetn, .scan_strobe, .enable_in, .req,
    .rsp, .done);
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, s);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic op(input logic en, input logic [7:0] f, input logic dw,
    input logic [31:0] a, b, input logic [4:0] k);
    bslu_seq_model_inst.fire(en, '{f, dw, a, b, k, 1'b1});
    chk("done", 32'h1, 32'(done));
  endtask
  function automatic logic [31:0] lo();
    return {16'h0000, rsp.result_dest_ref[15:0]};
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_and_or();
    op(1'b1, BSLU_FN_AND, 1'b1, 32'hFFFF_0151, 32'h0000_015A, 5'h00);
    chk("and", 32'h0150, lo());
    chk("and_pw", 32'h3, 32'({rsp.power_flow, rsp.result_write}));
    op(1'b1, BSLU_FN_OR, 1'b0, 32'h0000_0151, 32'h0000_015A, 5'h00);
    chk("or", 32'h015B, lo());
  endtask
  task automatic t_off();
    op(1'b0, BSLU_FN_AND, 1'b0, 32'h0000_1FC8, 32'h0000_E037, 5'h00);
    chk("held", 32'h015B, lo());
    chk("off_pw", 32'h0, 32'({rsp.power_flow, rsp.result_write}));
    op(1'b1, BSLU_FN_XOR, 1'b0, 32'h0000_1FC8, 32'h0000_E037, 5'h00);
    chk("xor", 32'hFFFF, lo());
    op(1'b1, BSLU_FN_NOT, 1'b0, 32'h0000_1FC8, 32'h0, 5'h00);
    chk("not", 32'hE037, lo());
  endtask
  task automatic t_move();
    op(1'b1, BSLU_FN_ROTATE_TOWARD_MSB, 1'b1, 32'h1234_5678, 32'h0, 5'h04);
    chk("rot_msb", 32'h2345_6781, rsp.result_dest_ref);
    op(1'b1, BSLU_FN_ROTATE_TOWARD_LSB, 1'b0, 32'h0000_1234, 32'h0, 5'h04);
    chk("rot_lsb", 32'h4123, lo());
    op(1'b1, BSLU_FN_SHIFT_TOWARD_LSB, 1'b1, 32'h8000_0001, 32'h0, 5'h08);
    chk("shift_lsb", 32'h0080_0000, rsp.result_dest_ref);
    op(1'b1, BSLU_FN_SHIFT_TOWARD_MSB, 1'b0, 32'h0000_8001, 32'h0, 5'h01);
    chk("shift_msb", 32'h0003, lo());
    chk("shift_msb_pw", 32'h1, 32'(rsp.power_flow));
    // Zero fill and a zero pushed out of the top end
    bslu_seq_model_inst.fire(1'b1, '{BSLU_FN_SHIFT_TOWARD_MSB, 1'b1,
      32'h0000_0003, 32'h0, 5'h02, 1'b0});
    chk("shift_msb_fill0", 32'h0000_000C, rsp.result_dest_ref);
    chk("shift_msb_pw0", 32'h0, 32'(rsp.power_flow));
  endtask
  task automatic t_bits();
    op(1'b1, BSLU_FN_SET, 1'b1, 32'h0, 32'h0, 5'h1F);
    chk("set", 32'h8000_0000, rsp.result_dest_ref);
    op(1'b1, BSLU_FN_CLR, 1'b0, 32'h0000_FFFF, 32'h0, 5'h00);
    chk("clr", 32'hFFFE, lo());
    op(1'b1, BSLU_FN_TST, 1'b0, 32'h0000_0008, 32'h0, 5'h03);
    chk("tst", 32'h1, 32'(rsp.probe_bit));
    op(1'b1, BSLU_FN_POS, 1'b1, 32'h0010_0000, 32'h0, 5'h00);
    chk("pos", 32'h34, 32'({rsp.found, rsp.position}));
  endtask
  task automatic results();
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    t_and_or();
    t_off();
    t_move();
    t_bits();
    results();
  end
  // About 48 cycles of work; ten times that before giving up
  initial
  begin
    #5000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
